// [src/owls_top.sv]
// How it works
// - Sequential: one stored value per output clock, to its own channel.
// - Continuous sequential: sync, group-last and burst-last all ignored.
// - Simultaneous: values wait in holding registers until group-last.
// - After group-last, next output clock updates every channel together.
// - Continuous simul: sync and burst-last ignored, group-last delimits.
// - Burst mode starts on a sync event, stops at burst-last value.
// - Each later sync event plays the next stored function in order.
// - Burst sequential: one channel per clock, group-last ignored.
// - Board control bit 8 selects simultaneous over sequential clocking.
// - Board control bit 9 selects burst sync over continuous sync.
// - Writing board control with bit 11 set acts as sync event.
// - Burst end clears bit 11 and raises selected output request.
// - Looping buffer replays stored contents without consuming them.
// - Output group condition in bits 10:8, value 3; flag bit 11.
// - Request flag stays set until software writes it to zero.
`timescale 1ns/1ps
`default_nettype none
module owls_top #(
  parameter int AW = owls_pkg::OWLS_BUF_AW,
  parameter int NCH = owls_pkg::OWLS_NCH,
  parameter int DW = owls_pkg::OWLS_VAL_W
) (
  // Clock and reset
  input wire logic clock,
  input wire logic srst,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_wdata,
  output logic [31:0] reg_rdata,
  // External pins
  input wire logic ext_clock_pin,
  input wire logic ext_sync_pin,
  // Channel outputs
  output logic [NCH*DW-1:0] dac_value,
  output logic [NCH-1:0] dac_strobe,
  output logic out_group_request,
  output logic burst_active
);
  import owls_pkg::*;

  localparam int SW = OWLS_SAMPLE_W;

  typedef struct packed {
    logic [31:0] bc;
    logic [OWLS_IC_W-1:0] ic;
    logic [1:0][16:0] rate;
    logic [31:0] cs;
    logic [1:0][OWLS_RD_DIV_W-1:0] div;
    logic [2:0] ck_s;
    logic ck_l;
    logic [2:0] sy_s;
    logic sy_l;
    logic [AW:0] wptr;
    logic [AW-1:0] rptr;
    logic infl;
    owls_state_e st;
    logic [NCH-1:0][DW-1:0] hold;
    logic grp_rdy;
    logic grp_burst;
    logic [NCH-1:0][DW-1:0] chan;
    logic [NCH-1:0] stb;
    logic [31:0] rdata;
  } owls_top_s;

  owls_top_s s_q;
  owls_top_s s_d;

  owls_path_if #(.W(SW), .AW(AW)) path ();

  // Sample store and the two-entry buffer behind it
  owls_mem #(.W(SW), .AW(AW)) u_mem (
    .clock(clock),
    .p(path.mem)
  );

  owls_skid #(.W(SW)) u_skid (
    .clock(clock),
    .srst(srst),
    .p(path.fifo)
  );

  // Register hit decode, shared by reads and writes
  function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
    return a == o;
  endfunction : hit

  // Combinational helpers
  logic [1:0] rate_tick;
  logic ck_rise;
  logic sy_rise;
  logic out_tick;
  logic sync_evt;
  logic simul;
  logic burst;
  logic run;
  logic clr;
  logic restart;
  logic issue;
  logic done;
  logic [SW-1:0] word;
  logic [$clog2(NCH)-1:0] wch;
  logic glast;
  logic blast;

  // Divider ticks: divisor of zero ticks every cycle
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      rate_tick[i] = !s_q.rate[i][OWLS_RD_OFF_BIT] &&
        (s_q.div[i] >= s_q.rate[i][OWLS_RD_DIV_W-1:0]);
    end
  end

  // Pin edges count only once the last two stages agree
  assign ck_rise = (s_q.ck_s[1] == s_q.ck_s[2]) && s_q.ck_s[2] && !s_q.ck_l;
  assign sy_rise = (s_q.sy_s[1] == s_q.sy_s[2]) && s_q.sy_s[2] && !s_q.sy_l;

  // Output clock source, gated by the disable bit
  always_comb begin
    case (s_q.cs[1:0])
      OWLS_SRC_RATE_FIRST: out_tick = rate_tick[0];
      OWLS_SRC_RATE_SECOND: out_tick = rate_tick[1];
      OWLS_SRC_EXT_CLOCK: out_tick = ck_rise;
      default: out_tick = 1'b0;
    endcase
    if (s_q.cs[OWLS_CS_CLKOFF_BIT]) begin
      out_tick = 1'b0;
    end
  end

  // Mode decode
  assign simul = s_q.bc[OWLS_BC_SIMUL_BIT];
  assign burst = s_q.bc[OWLS_BC_BURST_BIT];
  assign clr = reg_wr && hit(reg_addr, OWLS_OFF_BOARD_CONTROL) &&
    reg_wdata[OWLS_BC_CLEAR_BIT];
  // A software trigger is a write with the sync bit set
  assign sync_evt = sy_rise || (reg_wr &&
    hit(reg_addr, OWLS_OFF_BOARD_CONTROL) && reg_wdata[OWLS_BC_SYNC_BIT]);
  // Continuous mode never looks at the sync state
  assign run = burst ? (s_q.st == OWLS_RUN) : 1'b1;

  // Fields of the head word
  assign word = path.pop_data;
  assign wch = word[OWLS_CH_LSB +: $clog2(NCH)];
  assign glast = word[OWLS_GLAST_BIT];
  assign blast = word[OWLS_BLAST_BIT];

  // Store write or clear rewinds the fetch, so no stale word is replayed
  assign restart = clr || path.mem_we;
  // One read in flight at most, so the buffer can never overflow
  assign issue = !s_q.infl && path.push_ready && (s_q.wptr != '0) &&
    !restart;

  // Memory and buffer hookup
  assign path.mem_we = reg_wr && hit(reg_addr, OWLS_OFF_OUTPUT_SAMPLE_BUFFER)
    && !s_q.wptr[AW];
  assign path.mem_waddr = s_q.wptr[AW-1:0];
  assign path.mem_wdata = reg_wdata[SW-1:0];
  assign path.mem_re = issue;
  assign path.mem_raddr = s_q.rptr;
  assign path.push = s_q.infl && !restart;
  assign path.push_data = path.mem_rdata;
  assign path.flush = restart;

  // Sequencer, register file and pin sampling
  always_comb begin
    s_d = s_q;
    s_d.stb = '0;
    path.pop = 1'b0;
    done = 1'b0;

    // Pin synchronisers and agreed levels
    s_d.ck_s = {s_q.ck_s[1:0], ext_clock_pin};
    s_d.sy_s = {s_q.sy_s[1:0], ext_sync_pin};
    if (s_q.ck_s[1] == s_q.ck_s[2]) begin
      s_d.ck_l = s_q.ck_s[2];
    end
    if (s_q.sy_s[1] == s_q.sy_s[2]) begin
      s_d.sy_l = s_q.sy_s[2];
    end

    // Divider counters restart on every tick
    for (int i = 0; i < 2; i++) begin
      if (s_q.rate[i][OWLS_RD_OFF_BIT] || rate_tick[i]) begin
        s_d.div[i] = '0;
      end else begin
        s_d.div[i] = s_q.div[i] + 16'h1;
      end
    end

    // Fetch runs ahead; the pointer wraps behind the last word
    s_d.infl = issue;
    if (issue) begin
      if ((AW + 1)'(s_q.rptr) + (AW + 1)'(1) == s_q.wptr) begin
        s_d.rptr = '0;
      end else begin
        s_d.rptr = s_q.rptr + AW'(1);
      end
    end

    // Burst start: idle until a sync event, then resume in place
    if (burst && s_q.st == OWLS_IDLE && sync_evt) begin
      s_d.st = OWLS_RUN;
    end

    if (!simul) begin
      // One word per output clock, group marker unused
      if (run && out_tick && path.pop_valid) begin
        path.pop = 1'b1;
        s_d.chan[wch] = word[DW-1:0];
        s_d.stb[wch] = 1'b1;
        if (burst && blast) begin
          done = 1'b1;
        end
      end
    end else if (run && s_q.grp_rdy) begin
      // Whole group goes out on the clock after it closed
      if (out_tick) begin
        s_d.chan = s_q.hold;
        s_d.stb = '1;
        s_d.grp_rdy = 1'b0;
        if (burst && s_q.grp_burst) begin
          done = 1'b1;
        end
      end
    end else if (run && path.pop_valid) begin
      // Collect a group into the holding registers
      path.pop = 1'b1;
      s_d.hold[wch] = word[DW-1:0];
      if (glast || (burst && blast)) begin
        s_d.grp_rdy = 1'b1;
        s_d.grp_burst = blast;
      end
    end

    // Board control write, buffer clear bit never stored
    if (reg_wr && hit(reg_addr, OWLS_OFF_BOARD_CONTROL)) begin
      s_d.bc = reg_wdata;
      s_d.bc[OWLS_BC_CLEAR_BIT] = 1'b0;
      if (!reg_wdata[OWLS_BC_BURST_BIT]) begin
        s_d.st = OWLS_IDLE;
      end
    end

    // Request flags: zero clears, one leaves as is
    if (reg_wr && hit(reg_addr, OWLS_OFF_INTERRUPT_CONTROL)) begin
      s_d.ic = (reg_wdata[OWLS_IC_W-1:0] & ~OWLS_IC_REQ_MASK) |
        (s_q.ic & reg_wdata[OWLS_IC_W-1:0] & OWLS_IC_REQ_MASK);
    end

    // Burst end; a fresh trigger in the same write is kept
    if (done) begin
      s_d.st = OWLS_IDLE;
      if (!(reg_wr && hit(reg_addr, OWLS_OFF_BOARD_CONTROL) &&
          reg_wdata[OWLS_BC_SYNC_BIT])) begin
        s_d.bc[OWLS_BC_SYNC_BIT] = 1'b0;
      end else begin
        s_d.st = OWLS_RUN;
      end
      // Set wins over a clear in the same cycle
      if (s_q.ic[OWLS_IC_G2_COND_LSB +: 3] == OWLS_COND_BURST_DONE) begin
        s_d.ic[OWLS_IC_G2_REQ_BIT] = 1'b1;
      end
    end

    // Rate dividers and clock source select
    for (int i = 0; i < 2; i++) begin
      if (reg_wr && hit(reg_addr, OWLS_OFF_RATE_DIVIDER_FIRST + 8'(4 * i)))
      begin
        s_d.rate[i] = reg_wdata[16:0];
      end
    end
    if (reg_wr && hit(reg_addr, OWLS_OFF_CLOCK_SOURCE_SELECT)) begin
      s_d.cs = reg_wdata;
    end

    // Appending to the stored function; full store drops writes
    if (path.mem_we) begin
      s_d.wptr = s_q.wptr + (AW + 1)'(1);
    end

    // Loading while running restarts the function at its first word
    if (restart) begin
      s_d.rptr = '0;
      s_d.infl = 1'b0;
      s_d.grp_rdy = 1'b0;
      s_d.grp_burst = 1'b0;
    end
    if (clr) begin
      s_d.wptr = '0;
      s_d.st = OWLS_IDLE;
    end

    // Read data, held between reads
    if (reg_rd) begin
      s_d.rdata = '0;
      if (hit(reg_addr, OWLS_OFF_BOARD_CONTROL)) begin
        s_d.rdata = s_q.bc;
      end
      if (hit(reg_addr, OWLS_OFF_INTERRUPT_CONTROL)) begin
        s_d.rdata = 32'(s_q.ic);
      end
      if (hit(reg_addr, OWLS_OFF_RATE_DIVIDER_FIRST)) begin
        s_d.rdata = 32'(s_q.rate[0]);
      end
      if (hit(reg_addr, OWLS_OFF_RATE_DIVIDER_SECOND)) begin
        s_d.rdata = 32'(s_q.rate[1]);
      end
      if (hit(reg_addr, OWLS_OFF_CLOCK_SOURCE_SELECT)) begin
        s_d.rdata = s_q.cs;
      end
    end
  end

  // State register, reset values from the package
  always_ff @(posedge clock) begin
    if (srst) begin
      s_q <= '0;
      s_q.bc <= OWLS_BC_RST;
      s_q.ic <= OWLS_IC_RST;
      s_q.rate[0] <= OWLS_RD_RST;
      s_q.rate[1] <= OWLS_RD_RST;
      s_q.cs <= OWLS_CS_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs from flip-flops, burst_active through one AND gate
  assign reg_rdata = s_q.rdata;
  assign dac_value = s_q.chan;
  assign dac_strobe = s_q.stb;
  assign out_group_request = s_q.ic[OWLS_IC_G2_REQ_BIT];
  assign burst_active = burst && (s_q.st == OWLS_RUN);
endmodule : owls_top
`default_nettype wire

// [inc/owls_pkg.sv]
package owls_pkg;

  // Register byte offsets
  localparam logic [7:0] OWLS_OFF_BOARD_CONTROL = 8'h00;
  localparam logic [7:0] OWLS_OFF_INTERRUPT_CONTROL = 8'h04;
  localparam logic [7:0] OWLS_OFF_RATE_DIVIDER_FIRST = 8'h10;
  localparam logic [7:0] OWLS_OFF_RATE_DIVIDER_SECOND = 8'h14;
  localparam logic [7:0] OWLS_OFF_OUTPUT_SAMPLE_BUFFER = 8'h18;
  localparam logic [7:0] OWLS_OFF_CLOCK_SOURCE_SELECT = 8'h20;

  // Board control fields
  localparam int OWLS_BC_SIMUL_BIT = 8;
  localparam int OWLS_BC_BURST_BIT = 9;
  localparam int OWLS_BC_SYNC_BIT = 11;
  localparam int OWLS_BC_CLEAR_BIT = 13;

  // Interrupt control fields
  localparam int OWLS_IC_W = 12;
  localparam int OWLS_IC_G2_COND_LSB = 8;
  localparam int OWLS_IC_G2_REQ_BIT = 11;
  localparam logic [OWLS_IC_W-1:0] OWLS_IC_REQ_MASK = 12'h888;
  localparam logic [2:0] OWLS_COND_BURST_DONE = 3'h3;

  // Clock source select fields
  localparam int OWLS_CS_CLKOFF_BIT = 5;
  localparam logic [1:0] OWLS_SRC_RATE_FIRST = 2'h0;
  localparam logic [1:0] OWLS_SRC_RATE_SECOND = 2'h1;
  localparam logic [1:0] OWLS_SRC_EXT_CLOCK = 2'h2;

  // Rate divider fields
  localparam int OWLS_RD_OFF_BIT = 16;
  localparam int OWLS_RD_DIV_W = 16;

  // Stored sample word layout
  localparam int OWLS_VAL_W = 12;
  localparam int OWLS_CH_LSB = 16;
  localparam int OWLS_GLAST_BIT = 18;
  localparam int OWLS_BLAST_BIT = 19;
  localparam int OWLS_SAMPLE_W = 20;

  // Sizes
  localparam int OWLS_BUF_AW = 15;
  localparam int OWLS_NCH = 4;

  // Values after reset
  localparam logic [31:0] OWLS_BC_RST = 32'h0000_0000;
  localparam logic [OWLS_IC_W-1:0] OWLS_IC_RST = 12'h008;
  localparam logic [16:0] OWLS_RD_RST = 17'h1_0000;
  localparam logic [31:0] OWLS_CS_RST = 32'h0000_0020;

  // Sequencer state
  typedef enum logic [0:0] {
    OWLS_IDLE = 1'b0,
    OWLS_RUN = 1'b1
  } owls_state_e;

endpackage : owls_pkg

// [inc/owls_path_if.sv]
`timescale 1ns/1ps
`default_nettype none
interface owls_path_if #(
  parameter int W = 20,
  parameter int AW = 15
);
  // Sample memory ports
  logic mem_we;
  logic [AW-1:0] mem_waddr;
  logic [W-1:0] mem_wdata;
  logic mem_re;
  logic [AW-1:0] mem_raddr;
  logic [W-1:0] mem_rdata;
  // Two-entry buffer ports
  logic push;
  logic push_ready;
  logic [W-1:0] push_data;
  logic pop;
  logic pop_valid;
  logic [W-1:0] pop_data;
  logic flush;

  modport seq (output mem_we, mem_waddr, mem_wdata, mem_re, mem_raddr,
    input mem_rdata, output push, push_data, pop, flush,
    input push_ready, pop_valid, pop_data);
  modport mem (input mem_we, mem_waddr, mem_wdata, mem_re, mem_raddr,
    output mem_rdata);
  modport fifo (input push, push_data, pop, flush,
    output push_ready, pop_valid, pop_data);
endinterface : owls_path_if
`default_nettype wire

// [src/owls_mem.sv]
`timescale 1ns/1ps
`default_nettype none
module owls_mem #(
  parameter int W = 20,
  parameter int AW = 15
) (
  // Clock
  input wire logic clock,
  // Access ports
  owls_path_if.mem p
);
  import owls_pkg::*;

  logic [W-1:0] ram [2**AW];
  logic [W-1:0] rdata_q;

  // Write port and registered read port
  always_ff @(posedge clock) begin
    if (p.mem_we) begin
      ram[p.mem_waddr] <= p.mem_wdata;
    end
    if (p.mem_re) begin
      rdata_q <= ram[p.mem_raddr];
    end
  end

  assign p.mem_rdata = rdata_q;
endmodule : owls_mem
`default_nettype wire

// [src/owls_skid.sv]
`timescale 1ns/1ps
`default_nettype none
module owls_skid #(
  parameter int W = 20
) (
  // Clock and reset
  input wire logic clock,
  input wire logic srst,
  // Buffer ports
  owls_path_if.fifo p
);
  import owls_pkg::*;

  typedef struct packed {
    logic [1:0][W-1:0] e;
    logic [1:0] cnt;
  } owls_skid_s;

  owls_skid_s s_q;
  owls_skid_s s_d;

  // Honest full and empty flags
  assign p.push_ready = (s_q.cnt != 2'h2);
  assign p.pop_valid = (s_q.cnt != 2'h0);
  assign p.pop_data = s_q.e[0];

  // Pop shifts the tail forward, push lands behind what remains
  always_comb begin
    s_d = s_q;
    if (p.pop && p.pop_valid) begin
      s_d.e[0] = s_q.e[1];
      s_d.cnt = s_q.cnt - 2'h1;
    end
    if (p.push && p.push_ready) begin
      s_d.e[s_d.cnt[0]] = p.push_data;
      s_d.cnt = s_d.cnt + 2'h1;
    end
    if (p.flush) begin
      s_d.cnt = 2'h0;
    end
  end

  // State register
  always_ff @(posedge clock) begin
    if (srst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
endmodule : owls_skid
`default_nettype wire

// [verification/owls_chk.sv]
`timescale 1ns/1ps
`default_nettype none
module owls_chk #(
  parameter int NCH = 4,
  parameter int DW = 12
) (
  // Clock and reset
  input wire logic clock,
  input wire logic srst,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [31:0] reg_wdata,
  // Outputs
  input wire logic [NCH*DW-1:0] dac_value,
  input wire logic [NCH-1:0] dac_strobe,
  input wire logic out_group_request,
  input wire logic burst_active
);
  logic burst_q;
  logic simul_q;
  wire logic bc_wr = reg_wr && reg_addr == 8'h00;

  // Mode shadow, only the mode bits of board control matter here
  always_ff @(posedge clock) begin
    if (srst) begin
      burst_q <= 1'b0;
      simul_q <= 1'b0;
    end else if (bc_wr) begin
      burst_q <= reg_wdata[9];
      simul_q <= reg_wdata[8];
    end
  end

  default clocking @(posedge clock); endclocking
  default disable iff (srst);

  property p_seq_one;
    !simul_q && (|dac_strobe) |-> $onehot(dac_strobe);
  endproperty
  a_seq_one: assert property (p_seq_one)
    else $error("sequential update hit several channels");

  property p_seq_ch0;
    !simul_q && dac_strobe[0] |-> $stable(dac_value[NCH*DW-1:DW]);
  endproperty
  a_seq_ch0: assert property (p_seq_ch0)
    else $error("sequential update changed other channels");

  property p_sim_all;
    simul_q && (|dac_strobe) |-> dac_strobe == {NCH{1'b1}};
  endproperty
  a_sim_all: assert property (p_sim_all)
    else $error("simultaneous update not on all channels");

  property p_hold_val;
    dac_strobe == '0 |-> $stable(dac_value);
  endproperty
  a_hold_val: assert property (p_hold_val)
    else $error("channel value moved without strobe");

  property p_burst_idle;
    (burst_q && !burst_active) [*3] |-> dac_strobe == '0;
  endproperty
  a_burst_idle: assert property (p_burst_idle)
    else $error("channel update outside a burst");

  property p_trig;
    bc_wr && reg_wdata[9] && reg_wdata[11] && !reg_wdata[13] && !burst_active
      |-> ##[1:2] burst_active;
  endproperty
  a_trig: assert property (p_trig)
    else $error("software sync did not start a burst");

  property p_req_hold;
    out_group_request && !(reg_wr && reg_addr == 8'h04 && !reg_wdata[11])
      |=> out_group_request;
  endproperty
  a_req_hold: assert property (p_req_hold)
    else $error("request flag dropped without a clearing write");

  property p_req_cause;
    $rose(out_group_request) |-> $past(burst_active);
  endproperty
  a_req_cause: assert property (p_req_cause)
    else $error("request flag set without a burst ending");
endmodule : owls_chk

bind owls_top owls_chk #(.NCH(NCH), .DW(DW)) u_chk (
  .clock(clock),
  .srst(srst),
  .reg_addr(reg_addr),
  .reg_wr(reg_wr),
  .reg_wdata(reg_wdata),
  .dac_value(dac_value),
  .dac_strobe(dac_strobe),
  .out_group_request(out_group_request),
  .burst_active(burst_active)
);
`default_nettype wire

// [verification/owls_host.sv]
`timescale 1ns/1ps
`default_nettype none
module owls_host (
  // Clock
  input wire logic clock,
  // Register port
  output logic [7:0] reg_addr,
  output logic reg_wr,
  output logic reg_rd,
  output logic [31:0] reg_wdata,
  input wire logic [31:0] reg_rdata
);
  // Short divisor keeps ticks four cycles apart
  localparam logic [31:0] DIV = 32'h0000_0003;

  // Idle bus
  initial begin
    reg_addr = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_wdata = 32'h0000_0000;
  end

  // Write data is scrambled after use so stale values never look valid
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(negedge clock);
    reg_addr = a;
    reg_wdata = v;
    reg_wr = 1'b1;
    @(negedge clock);
    reg_wr = 1'b0;
    reg_wdata = ~v;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(negedge clock);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clock);
    reg_rd = 1'b0;
    d = reg_rdata;
  endtask : rd

  // Clock off and dividers held before any setup
  task automatic stop();
    wr(8'h20, 32'h0000_0020);
    wr(8'h10, DIV | 32'h0001_0000);
    wr(8'h14, DIV | 32'h0001_0000);
  endtask : stop

  // Modes first, clock source next, divider released last
  task automatic start(input logic [31:0] bc, input logic [31:0] ic);
    wr(8'h00, bc);
    wr(8'h04, ic);
    wr(8'h20, 32'h0000_0000);
    wr(8'h10, DIV);
  endtask : start

  // Sync write starts a burst, then waits until the sync bit has cleared
  task automatic trigger(input logic [31:0] bc, output logic [31:0] d);
    int n;
    wr(8'h00, bc | 32'h0000_0800);
    n = 0;
    do begin
      rd(8'h00, d);
      n++;
    end while (d[11] !== 1'b0 && n < 500);
  endtask : trigger
endmodule : owls_host
`default_nettype wire

// [verification/tb_output_waveform_loop_sequencer.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_output_waveform_loop_sequencer;
  import owls_pkg::*;
  logic clock = 1'b0;
  logic srst = 1'b1;
  logic ext_sync_pin = 1'b0;
  logic ext_clock_pin = 1'b0;
  logic [7:0] reg_addr;
  logic reg_wr;
  logic reg_rd;
  logic [31:0] reg_wdata;
  logic [31:0] reg_rdata;
  logic [47:0] dac_value;
  logic [3:0] dac_strobe;
  logic out_group_request;
  logic burst_active;
  int fails = 0;
  int n_compared = 0;
  logic [51:0] ev[$];
  logic [19:0] wq[$];
  logic [31:0] d;
  logic [7:0] ra[7] = '{8'h00, 8'h04, 8'h10, 8'h14, 8'h18, 8'h20, 8'h08};
  logic [31:0] rv[7] = '{32'h0, 32'h8, 32'h1_0000, 32'h1_0000, 32'h0,
    32'h20, 32'h0};

  always #5 clock = ~clock;

  // Free running external output clock, one rise every eight cycles
  always begin
    repeat (4) @(negedge clock);
    ext_clock_pin = ~ext_clock_pin;
  end

  owls_top #(.AW(4)) u_dut (
    .clock(clock), .srst(srst), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .ext_clock_pin(ext_clock_pin), .ext_sync_pin(ext_sync_pin),
    .dac_value(dac_value), .dac_strobe(dac_strobe),
    .out_group_request(out_group_request), .burst_active(burst_active));

  owls_host u_host (
    .clock(clock), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));

  // Every channel update, taken mid-cycle where it has settled
  always @(negedge clock) begin
    if (!srst && dac_strobe != 4'h0) begin
      ev.push_back({dac_strobe, dac_value});
    end
  end

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask : check

  task automatic summarize();
    $display("Compared %0d, mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : summarize

  function automatic logic [19:0] mk_word(input int ch, input bit gl,
    input bit bl);
    return {bl, gl, 2'(ch), 4'h0, 12'($urandom)};
  endfunction : mk_word

  task automatic load(input logic [19:0] w);
    wq.push_back(w);
    u_host.wr(8'h18, {12'h000, w});
  endtask : load

  // Empty store, nothing left in flight
  task automatic fresh();
    u_host.stop();
    repeat (4) @(negedge clock);
    u_host.wr(8'h00, 32'h0000_2000);
    wq.delete();
    ev.delete();
  endtask : fresh

  task automatic wait_ev(input int n);
    int t;
    t = 0;
    while (ev.size() < n && t < 3000) begin
      @(negedge clock);
      t++;
    end
  endtask : wait_ev

  task automatic pulse_sync();
    @(negedge clock) ext_sync_pin = 1'b1;
    repeat (4) @(negedge clock);
    ext_sync_pin = 1'b0;
  endtask : pulse_sync

  // One channel per update, store replayed in a loop
  task automatic expect_seq(input int base, input int n);
    logic [51:0] e;
    logic [19:0] w;
    wait_ev(n);
    for (int i = 0; i < n; i++) begin
      e = (ev.size() != 0) ? ev.pop_front() : 'x;
      w = wq[(base + i) % wq.size()];
      check(e[51:48], 4'h1 << w[17:16]);
      check(e[12*w[17:16] +: 12], w[11:0]);
    end
  endtask : expect_seq

  // Whole group of four lands in one update
  task automatic expect_sim(input int n);
    logic [51:0] e;
    logic [19:0] w;
    wait_ev(n);
    for (int i = 0; i < n; i++) begin
      e = (ev.size() != 0) ? ev.pop_front() : 'x;
      check(e[51:48], 4'hf);
      for (int c = 0; c < 4; c++) begin
        w = wq[(4 * i + c) % wq.size()];
        check(e[12*w[17:16] +: 12], w[11:0]);
      end
    end
  endtask : expect_sim

  // Hang guard, far beyond the few hundred cycles the tests need
  initial begin
    repeat (20000) @(posedge clock);
    fails++;
    summarize();
  end

  initial begin
    void'($urandom(83));
    repeat (6) @(posedge clock);
    @(negedge clock) srst = 1'b0;
    for (int i = 0; i < 7; i++) begin
      u_host.rd(ra[i], d);
      check(d, rv[i]);
    end
    // Continuous sequential, random markers and sync must not matter
    fresh();
    repeat (5) load(mk_word($urandom % 4, 1'($urandom), 1'($urandom)));
    u_host.start(32'h0000_4460, 32'h0);
    pulse_sync();
    expect_seq(0, 12);
    // Continuous simultaneous, burst-last in first group ignored
    fresh();
    for (int g = 0; g < 2; g++) begin
      for (int c = 0; c < 4; c++) begin
        load(mk_word(c, c == 3, g == 0 && c == 3));
      end
    end
    u_host.start(32'h0000_4560, 32'h0);
    u_host.wr(8'h20, 32'h0000_0002);
    pulse_sync();
    expect_sim(4);
    // Burst sequential, two functions back to back
    fresh();
    load(mk_word(0, 1, 0));
    load(mk_word(3, 0, 0));
    load(mk_word(1, 0, 1));
    load(mk_word(2, 0, 0));
    load(mk_word(2, 0, 1));
    u_host.start(32'h0000_4660, 32'h0000_0300);
    repeat (40) @(negedge clock);
    check(ev.size(), 0);
    u_host.trigger(32'h0000_4660, d);
    check(d, 32'h0000_4660);
    check(burst_active, 1'b0);
    repeat (4) @(negedge clock);
    check(ev.size(), 3);
    expect_seq(0, 3);
    u_host.rd(8'h04, d);
    check(d, 32'h0000_0b00);
    check(out_group_request, 1'b1);
    u_host.wr(8'h04, 32'h0000_0300);
    u_host.rd(8'h04, d);
    check(d, 32'h0000_0300);
    check(out_group_request, 1'b0);
    pulse_sync();
    for (int t = 0; t < 500 && out_group_request !== 1'b1; t++) begin
      @(negedge clock);
    end
    check(out_group_request, 1'b1);
    repeat (4) @(negedge clock);
    check(ev.size(), 2);
    expect_seq(3, 2);
    u_host.trigger(32'h0000_4660, d);
    check(d, 32'h0000_4660);
    repeat (4) @(negedge clock);
    check(ev.size(), 3);
    expect_seq(0, 3);
    // Burst simultaneous, one group closing the burst
    fresh();
    for (int c = 0; c < 4; c++) begin
      load(mk_word(c, c == 3, c == 3));
    end
    u_host.start(32'h0000_4760, 32'h0000_0300);
    u_host.wr(8'h14, 32'h0000_0003);
    u_host.wr(8'h20, 32'h0000_0001);
    u_host.trigger(32'h0000_4760, d);
    check(d, 32'h0000_4760);
    repeat (4) @(negedge clock);
    check(ev.size(), 1);
    expect_sim(1);
    summarize();
  end
endmodule : tb_output_waveform_loop_sequencer
`default_nettype wire
